// ---- adc_ctl_pkg.sv ----
package adc_ctl_pkg;

  localparam int MCLK_HZ   = 125_000_000;
  localparam int SAMPLE_HZ = 1_000_000;
  localparam int SAMPLE_DIV = MCLK_HZ / SAMPLE_HZ;
  localparam int WAKE_NS   = 6000;
  localparam int WAKE_CYC  =
    (WAKE_NS * (MCLK_HZ / 1_000_000) + 999) / 1000;
  localparam int PDM_HZ    = 1_600_000;
  localparam int PDM_HALF  = MCLK_HZ / (2 * PDM_HZ);

  // Byte offsets on the register bus.
  localparam logic [5:0] OFS_CTRL   = 6'h00;
  localparam logic [5:0] OFS_CONF   = 6'h04;
  localparam logic [5:0] OFS_RESULT = 6'h14;
  localparam logic [5:0] OFS_CORR   = 6'h18;
  localparam logic [5:0] OFS_STATUS = 6'h20;
  localparam logic [5:0] OFS_UPPER  = 6'h24;
  localparam logic [5:0] OFS_LOWER  = 6'h28;

  // Status register bit positions.
  localparam int ST_BUSY = 0;
  localparam int ST_CAL  = 1;
  localparam int ST_CONV = 2;
  localparam int ST_WIN  = 3;

  localparam logic [31:0] UPPER_RST = 32'hffffffff;
  localparam logic [31:0] LOWER_RST = 32'h00000000;
  localparam logic [2:0]  SEL_SHORT = 3'h6;

  typedef struct packed {
    logic       auto_trim_enable;
    logic       mic_conversion_on;
    logic       stop;
    logic       soft_reset;
    logic       software_start;
    logic       calibration_enable;
    logic       converter_on;
  } ctrl_t;

  typedef struct packed {
    logic       window_compare_enable;
    logic       pdm_clock_halve;
    logic       mic_clock_select;
    logic       filter_bypass;
    logic [1:0] reference_select;
    logic [1:0] input_attenuation;
    logic [1:0] oversampling_ratio;
    logic       continuous_select;
    logic [2:0] input_select;
  } conf_t;

  localparam ctrl_t CTRL_RST = '0;
  localparam conf_t CONF_RST = '0;

  typedef enum logic [2:0] {
    ST_IDLE, ST_WAKE, ST_CALIB, ST_ACQ, ST_ELAB, ST_MIC
  } seq_state_t;

  function automatic logic [7:0] ratio_of(input logic [1:0] code);
    case (code)
      2'h0:    ratio_of = 8'd200;
      2'h1:    ratio_of = 8'd100;
      2'h2:    ratio_of = 8'd64;
      default: ratio_of = 8'd32;
    endcase
  endfunction : ratio_of

endpackage : adc_ctl_pkg

// ---- adc_conversion_control.sv ----
// Implementation choices: register access over Avalon-MM and the register offsets.
module adc_conversion_control
  import adc_ctl_pkg::*;
(
  // Clock and reset
  input  wire logic        i_mclk,
  input  wire logic        i_sys_rst,
  // Avalon-MM register slave
  input  wire logic [5:0]  i_address,
  input  wire logic        i_read,
  input  wire logic        i_write,
  input  wire logic [31:0] i_writedata,
  output logic      [31:0] o_readdata,
  output logic             o_waitrequest,
  // Analog front end
  input  wire logic        i_mod_bit,
  output logic      [2:0]  o_input_select,
  output logic      [1:0]  o_input_attenuation,
  output logic      [1:0]  o_reference_select,
  output logic             o_analog_on,
  output logic             o_calibrating,
  // Microphone link
  input  wire logic        i_in_a,
  output logic             o_pdm_clock_out
);

  ctrl_t             ctrl_r;
  conf_t             conf_r;
  logic [31:0]       result_r;
  logic [31:0]       corr_r;
  logic [31:0]       upper_r;
  logic [31:0]       lower_r;
  logic [3:0]        flags_r;
  seq_state_t        state_r;
  logic [9:0]        wake_cnt_r;
  logic [6:0]        tick_cnt_r;
  logic              tick_r;
  logic [2:0]        mic_sync_r;
  logic              mic_bit_r;
  logic [7:0]        pdm_cnt_r;
  logic              pdm_rise_r;
  logic [7:0]        samp_cnt_r;
  logic signed [15:0] acc_r;
  logic signed [15:0] filt_r;
  logic              filt_done_r;

  logic              bus_ok;
  logic              wr_ok;
  logic              strobe;
  logic              run;
  logic              in_bit;
  logic signed [15:0] corr_sel;
  logic signed [15:0] corrected;
  logic [31:0]       result_nxt;
  logic              res_wr;
  logic              win_hit;
  logic              busy;
  logic              start;
  logic [7:0]        pdm_half;
  logic              last_samp;
  logic signed [15:0] acc_step;

  //////////////////////////////////////////////////////////////////////////
  // Register bus.

  assign bus_ok = (i_read | i_write) & ~o_waitrequest;
  assign wr_ok  = i_write & ~o_waitrequest;

  always_ff @(posedge i_mclk)
  begin
    if (i_sys_rst)
      o_waitrequest <= 1'b1;
    else
      o_waitrequest <= ~((i_read | i_write) & o_waitrequest);
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_sys_rst)
      o_readdata <= '0;
    else if (i_read & o_waitrequest)
    begin
      case (i_address)
        OFS_CTRL:   o_readdata <= {25'h0, ctrl_r};
        OFS_CONF:   o_readdata <= {18'h0, conf_r};
        OFS_RESULT: o_readdata <= result_r;
        OFS_CORR:   o_readdata <= corr_r;
        OFS_STATUS: o_readdata <= {28'h0, flags_r};
        OFS_UPPER:  o_readdata <= upper_r;
        OFS_LOWER:  o_readdata <= lower_r;
        default:    o_readdata <= '0;
      endcase
    end
  end

  assign busy  = (state_r != ST_IDLE) && (state_r != ST_MIC);
  assign start = (state_r == ST_IDLE) & ctrl_r.converter_on
                 & ctrl_r.software_start;

  always_ff @(posedge i_mclk)
  begin
    if (i_sys_rst || ctrl_r.soft_reset)
      ctrl_r <= CTRL_RST;
    else if (wr_ok && i_address == OFS_CTRL)
      ctrl_r <= ctrl_t'(i_writedata[6:0]);
    else if (ctrl_r.stop)
    begin
      ctrl_r.stop              <= 1'b0;
      ctrl_r.converter_on      <= 1'b0;
      ctrl_r.software_start    <= 1'b0;
      ctrl_r.mic_conversion_on <= 1'b0;
    end
    else if (start)
      ctrl_r.software_start <= 1'b0;
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_sys_rst || ctrl_r.soft_reset)
      conf_r <= CONF_RST;
    else if (wr_ok && i_address == OFS_CONF && !busy)
      conf_r <= conf_t'(i_writedata[13:0]);
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_sys_rst || ctrl_r.soft_reset)
    begin
      upper_r <= UPPER_RST;
      lower_r <= LOWER_RST;
    end
    else if (wr_ok && i_address == OFS_UPPER)
      upper_r <= i_writedata;
    else if (wr_ok && i_address == OFS_LOWER)
      lower_r <= i_writedata;
  end

  //////////////////////////////////////////////////////////////////////////
  // Sample timing and microphone clock.

  always_ff @(posedge i_mclk)
  begin
    // Restarting the tick whenever the filter stops running makes its length exact.
    if (i_sys_rst || !run || tick_cnt_r == 7'(SAMPLE_DIV - 1))
      tick_cnt_r <= '0;
    else
      tick_cnt_r <= tick_cnt_r + 7'd1;
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_sys_rst)
      tick_r <= 1'b0;
    else
      tick_r <= (tick_cnt_r == 7'(SAMPLE_DIV - 1));
  end

  assign pdm_half = conf_r.pdm_clock_halve ? 8'(2 * PDM_HALF)
                                           : 8'(PDM_HALF);

  always_ff @(posedge i_mclk)
  begin
    if (i_sys_rst || !conf_r.mic_clock_select)
    begin
      pdm_cnt_r       <= '0;
      o_pdm_clock_out <= 1'b0;
      pdm_rise_r      <= 1'b0;
    end
    else if (pdm_cnt_r >= pdm_half - 8'd1)
    begin
      pdm_cnt_r       <= '0;
      o_pdm_clock_out <= ~o_pdm_clock_out;
      pdm_rise_r      <= ~o_pdm_clock_out;
    end
    else
    begin
      pdm_cnt_r  <= pdm_cnt_r + 8'd1;
      pdm_rise_r <= 1'b0;
    end
  end

  // The data pin settles only when two synchronised copies agree.
  always_ff @(posedge i_mclk)
  begin
    if (i_sys_rst)
    begin
      mic_sync_r <= '0;
      mic_bit_r  <= 1'b0;
    end
    else
    begin
      mic_sync_r <= {mic_sync_r[1:0], i_in_a};
      if (mic_sync_r[1] == mic_sync_r[2])
        mic_bit_r <= mic_sync_r[2];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Decimating filter shared by calibration, acquisition and microphone.

  assign run    = (state_r == ST_CALIB) || (state_r == ST_ACQ)
                  || (state_r == ST_MIC);
  assign strobe = (state_r == ST_MIC) ? pdm_rise_r : tick_r;
  assign in_bit = (state_r == ST_MIC) ? mic_bit_r : i_mod_bit;
  assign last_samp = samp_cnt_r == ratio_of(conf_r.oversampling_ratio) - 8'd1;
  // The sample taken on the last strobe still counts towards the result.
  assign acc_step  = in_bit ? acc_r + 16'sd1 : acc_r - 16'sd1;

  always_ff @(posedge i_mclk)
  begin
    if (i_sys_rst || !run)
    begin
      samp_cnt_r  <= '0;
      acc_r       <= '0;
      filt_done_r <= 1'b0;
    end
    else if (strobe)
    begin
      if (last_samp)
      begin
        samp_cnt_r  <= '0;
        acc_r       <= '0;
        filt_done_r <= 1'b1;
      end
      else
      begin
        samp_cnt_r  <= samp_cnt_r + 8'd1;
        acc_r       <= acc_step;
        filt_done_r <= 1'b0;
      end
    end
    else
      filt_done_r <= 1'b0;
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_sys_rst)
      filt_r <= '0;
    else if (run && strobe && last_samp)
      filt_r <= conf_r.filter_bypass ? acc_step : (acc_step <<< 6);
  end

  //////////////////////////////////////////////////////////////////////////
  // Conversion sequencer.

  always_ff @(posedge i_mclk)
  begin
    if (i_sys_rst || ctrl_r.soft_reset || ctrl_r.stop)
    begin
      state_r    <= ST_IDLE;
      wake_cnt_r <= '0;
    end
    else
    begin
      case (state_r)
        ST_IDLE:
        begin
          wake_cnt_r <= '0;
          if (start)
            state_r <= ST_WAKE;
          else if (ctrl_r.mic_conversion_on)
            state_r <= ST_MIC;
        end
        ST_WAKE:
        begin
          wake_cnt_r <= wake_cnt_r + 10'd1;
          if (wake_cnt_r == 10'(WAKE_CYC - 1))
            state_r <= (ctrl_r.calibration_enable
                        && ctrl_r.auto_trim_enable) ? ST_CALIB
                                                    : ST_ACQ;
        end
        ST_CALIB:
          if (filt_done_r)
            state_r <= ST_ACQ;
        ST_ACQ:
          if (filt_done_r)
            state_r <= ST_ELAB;
        ST_ELAB:
          state_r <= conf_r.continuous_select ? ST_ACQ : ST_IDLE;
        ST_MIC:
          if (!ctrl_r.mic_conversion_on)
            state_r <= ST_IDLE;
        default:
          state_r <= ST_IDLE;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Correction, result and window compare.

  assign corr_sel  = conf_r.filter_bypass ? $signed(corr_r[15:0])
                                          : $signed(corr_r[31:16]);
  assign corrected = filt_r - corr_sel;
  assign result_nxt = conf_r.filter_bypass ? {16'h0, corrected}
                                           : {corrected, 16'h0};
  assign res_wr = (state_r == ST_ELAB)
                  || (state_r == ST_MIC && filt_done_r);
  assign win_hit = conf_r.window_compare_enable
                   && result_nxt >= lower_r
                   && result_nxt <= upper_r;

  always_ff @(posedge i_mclk)
  begin
    if (i_sys_rst || ctrl_r.soft_reset)
      result_r <= '0;
    else if (res_wr)
      result_r <= result_nxt;
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_sys_rst)
      corr_r <= '0;
    else if (state_r == ST_CALIB && filt_done_r)
    begin
      if (conf_r.filter_bypass)
        corr_r[15:0] <= filt_r;
      else
        corr_r[31:16] <= filt_r;
    end
    else if (wr_ok && i_address == OFS_CORR)
      corr_r <= i_writedata;
  end

  // Hardware sets win over a software clear in the same cycle.
  always_ff @(posedge i_mclk)
  begin
    if (i_sys_rst)
      flags_r <= '0;
    else
    begin
      flags_r[ST_BUSY] <= busy;
      if (state_r == ST_CALIB && filt_done_r)
        flags_r[ST_CAL] <= 1'b1;
      else if (wr_ok && i_address == OFS_STATUS && i_writedata[ST_CAL])
        flags_r[ST_CAL] <= 1'b0;
      if (res_wr)
        flags_r[ST_CONV] <= 1'b1;
      else if (wr_ok && i_address == OFS_STATUS && i_writedata[ST_CONV])
        flags_r[ST_CONV] <= 1'b0;
      if (res_wr && win_hit)
        flags_r[ST_WIN] <= 1'b1;
      else if (wr_ok && i_address == OFS_STATUS && i_writedata[ST_WIN])
        flags_r[ST_WIN] <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Analog front-end controls.

  always_ff @(posedge i_mclk)
  begin
    if (i_sys_rst)
    begin
      o_input_select      <= '0;
      o_input_attenuation <= '0;
      o_reference_select  <= '0;
      o_analog_on         <= 1'b0;
      o_calibrating       <= 1'b0;
    end
    else
    begin
      o_input_select      <= (state_r == ST_CALIB) ? SEL_SHORT
                                                   : conf_r.input_select;
      o_input_attenuation <= conf_r.input_attenuation;
      o_reference_select  <= conf_r.reference_select;
      o_analog_on         <= busy;
      o_calibrating       <= (state_r == ST_CALIB);
    end
  end

endmodule : adc_conversion_control

// ---- adc_conversion_control_assertions.sv ----
module adc_ctl_checker
  import adc_ctl_pkg::*;
(
  // Clock and reset
  input wire logic        i_mclk,
  input wire logic        i_sys_rst,
  // Register bus
  input wire logic [5:0]  i_address,
  input wire logic        i_read,
  input wire logic        i_write,
  input wire logic [31:0] o_readdata,
  input wire logic        o_waitrequest,
  // Converter and microphone
  input wire logic [2:0]  o_input_select,
  input wire logic        o_analog_on,
  input wire logic        o_calibrating,
  input wire logic        o_pdm_clock_out
);
  logic        pclk_q;
  logic [15:0] rise_cnt;
  logic [15:0] on_cnt;
  logic [15:0] cal_cnt;

  // Cycles since the last rise of the microphone clock, saturating.
  always_ff @(posedge i_mclk)
  begin
    pclk_q <= o_pdm_clock_out;
    if (i_sys_rst)
      rise_cnt <= 16'hffff;
    else if (o_pdm_clock_out && !pclk_q)
      rise_cnt <= 16'h0000;
    else if (rise_cnt != 16'hffff)
      rise_cnt <= rise_cnt + 16'h0001;
  end

  always_ff @(posedge i_mclk)
  begin
    on_cnt  <= o_analog_on ? on_cnt + 16'h0001 : 16'h0000;
    cal_cnt <= o_calibrating ? cal_cnt + 16'h0001 : 16'h0000;
  end

  //////////////////////////////////////////////////////////////////////////
  default clocking @(posedge i_mclk);
  endclocking
  default disable iff (i_sys_rst);

  sequence bus_req;
    (i_read || i_write) && o_waitrequest;
  endsequence

  sequence one_ack;
    !o_waitrequest ##1 o_waitrequest;
  endsequence

  wait_one_a: assert property (bus_req |=> one_ack)
    else $error("waitrequest not low for exactly one cycle");
  wait_idle_a: assert property
    (!(i_read || i_write) && o_waitrequest |=> o_waitrequest)
    else $error("waitrequest dropped without a request");
  unmapped_zero_a: assert property
    (i_read && !o_waitrequest && i_address == 6'h3c |-> o_readdata == 32'h0)
    else $error("unmapped read not zero");
  pdm_period_a: assert property (
    o_pdm_clock_out && !pclk_q && rise_cnt < 16'h00c8
    |-> rise_cnt == 16'h004d || rise_cnt == 16'h009b)
    else $error("microphone clock period wrong");
  wake_len_a: assert property (
    $rose(o_calibrating) |-> on_cnt >= 16'h02e9 && on_cnt <= 16'h02f3)
    else $error("wake-up interval wrong");
  cal_short_a: assert property (
    o_calibrating && $past(o_calibrating) |-> o_input_select == SEL_SHORT)
    else $error("inputs not shorted in calibration");
  cal_busy_a: assert property (o_calibrating |-> o_analog_on)
    else $error("calibration outside a sequence");
  cal_len_a: assert property ($fell(o_calibrating) |-> cal_cnt inside
    {[16'h0f9b:16'h0fa5], [16'h1f3b:16'h1f45],
     [16'h30cf:16'h30d9], [16'h61a3:16'h61ad]})
    else $error("calibration length wrong");
endmodule : adc_ctl_checker

bind adc_conversion_control adc_ctl_checker u_adc_ctl_checker (
  .i_mclk, .i_sys_rst, .i_address, .i_read, .i_write, .o_readdata,
  .o_waitrequest, .o_input_select, .o_analog_on, .o_calibrating,
  .o_pdm_clock_out
);

// ---- mic_model.sv ----
module mic_model #(
  parameter int DLY_NS = 10
)
(
  // Clock from the block
  input  wire logic i_pdm_clock_out,
  // Bit stream towards the block
  output logic      o_data
);
  timeunit 1ns;
  timeprecision 1ns;

  initial
  begin
    o_data = 1'b1;
  end

  // A new bit follows each falling clock edge after the output delay.
  always @(negedge i_pdm_clock_out)
  begin
    o_data <= #(DLY_NS) 1'b1;
  end
endmodule : mic_model

// ---- adc_conversion_control_tb_top.sv ----
module adc_conversion_control_tb_top
  import adc_ctl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        i_mclk;
  logic        i_sys_rst;
  logic [5:0]  i_address;
  logic        i_read;
  logic        i_write;
  logic [31:0] i_writedata;
  logic [31:0] o_readdata;
  logic        o_waitrequest;
  logic        i_mod_bit;
  logic [2:0]  o_input_select;
  logic [1:0]  o_input_attenuation;
  logic [1:0]  o_reference_select;
  logic        o_analog_on;
  logic        o_calibrating;
  logic        i_in_a;
  logic        o_pdm_clock_out;
  logic [31:0] rd;
  int          n_errors = 0;
  int          n_tests = 0;

  adc_conversion_control u_adc_conversion_control (
    .i_mclk, .i_sys_rst, .i_address, .i_read, .i_write, .i_writedata,
    .o_readdata, .o_waitrequest, .i_mod_bit, .o_input_select,
    .o_input_attenuation, .o_reference_select, .o_analog_on,
    .o_calibrating, .i_in_a, .o_pdm_clock_out);
  mic_model #(.DLY_NS(200)) u_mic_model (.i_pdm_clock_out(o_pdm_clock_out),
    .o_data(i_in_a));

  //////////////////////////////////////////////////////////////////////////
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk

  task acc(input logic w, input logic [5:0] a, input logic [31:0] d);
    int n;
    n = 0;
    i_address   <= a;
    i_writedata <= d;
    i_write     <= w;
    i_read      <= !w;
    do
    begin
      @(posedge i_mclk);
      n++;
    end
    while (o_waitrequest !== 1'b0 && n < 20);
    rd = o_readdata;
    chk({31'h0, o_waitrequest}, 32'h0);
    i_write <= 1'b0;
    i_read  <= 1'b0;
    @(posedge i_mclk);
  endtask : acc

  task wait_flag(input int b);
    int n;
    n = 0;
    do
    begin
      acc(1'b0, OFS_STATUS, 32'h0);
      n++;
    end
    while (rd[b] !== 1'b1 && n < 10000);
    chk({31'h0, rd[b]}, 32'h1);
  endtask : wait_flag

  task start_conv(input logic [31:0] ctrl, input logic [31:0] exp);
    acc(1'b1, OFS_STATUS, 32'he);
    acc(1'b1, OFS_CTRL, ctrl);
    wait_flag(ST_CONV);
    acc(1'b0, OFS_RESULT, 32'h0);
    chk(rd & 32'h0000ffff, exp);
    acc(1'b0, OFS_STATUS, 32'h0);
  endtask : start_conv

  task pdm_period(input logic [31:0] exp);
    time t0;
    @(posedge o_pdm_clock_out);
    t0 = $time;
    @(posedge o_pdm_clock_out);
    chk(32'(($time - t0) / 8), exp);
    @(posedge i_mclk);
  endtask : pdm_period

  //////////////////////////////////////////////////////////////////////////
  task t_regs;
    acc(1'b0, OFS_CONF, 32'h0);
    chk(rd, 32'h0);
    acc(1'b0, OFS_UPPER, 32'h0);
    chk(rd, 32'hffffffff);
    acc(1'b1, 6'h3c, 32'h5a5a5a5a);
    acc(1'b0, 6'h3c, 32'h0);
    chk(rd, 32'h0);
    acc(1'b0, OFS_STATUS, 32'h0);
    chk(rd, 32'h0);
  endtask : t_regs

  // Filter bypassed, window 0x10..0x30, input 2 and configuration held while busy.
  task t_single;
    acc(1'b1, OFS_CORR, 32'h0);
    acc(1'b1, OFS_UPPER, 32'h30);
    acc(1'b1, OFS_LOWER, 32'h10);
    acc(1'b1, OFS_CONF, 32'h2432);
    i_mod_bit <= 1'b1;
    acc(1'b1, OFS_CTRL, 32'h5);
    wait_flag(ST_BUSY);
    chk(32'(o_input_select), 32'h2);
    acc(1'b1, OFS_CONF, 32'h0);
    acc(1'b0, OFS_CONF, 32'h0);
    chk(rd, 32'h2432);
    wait_flag(ST_CONV);
    acc(1'b0, OFS_RESULT, 32'h0);
    chk(rd, 32'h20);
    acc(1'b0, OFS_STATUS, 32'h0);
    chk(rd, 32'hc);
    chk({31'h0, o_analog_on}, 32'h0);
  endtask : t_single

  task t_calib;
    acc(1'b1, OFS_STATUS, 32'h4);
    acc(1'b1, OFS_CTRL, 32'h47);
    wait_flag(ST_CONV);
    acc(1'b0, OFS_CORR, 32'h0);
    chk(rd, 32'h20);
    acc(1'b0, OFS_RESULT, 32'h0);
    chk(rd, 32'h0);
    acc(1'b0, OFS_STATUS, 32'h0);
    chk(rd, 32'he);
    acc(1'b1, OFS_STATUS, 32'he);
    acc(1'b0, OFS_STATUS, 32'h0);
    chk(rd, 32'h0);
  endtask : t_calib

  // Ratio 200 on a DC input, reference 2 and attenuation 1 kept after the conversion.
  task t_keep;
    acc(1'b1, OFS_CONF, 32'h2642);
    i_mod_bit <= 1'b0;
    start_conv(32'h5, 32'hff18);
    chk(rd, 32'h4);
    chk(32'(o_reference_select), 32'h2);
    chk(32'(o_input_attenuation), 32'h1);
    acc(1'b1, OFS_CONF, 32'h2602);
  endtask : t_keep

  task t_upper;
    acc(1'b1, OFS_CONF, 32'h2032);
    i_mod_bit <= 1'b1;
    start_conv(32'h5, 32'h0);
    acc(1'b0, OFS_RESULT, 32'h0);
    chk(32'(rd[31:16]), 32'h800);
  endtask : t_upper

  // Continuous with the filter bypassed: three results are thrown away.
  task t_continuous_select;
    acc(1'b1, OFS_CONF, 32'h0438);
    acc(1'b1, OFS_STATUS, 32'he);
    acc(1'b1, OFS_CTRL, 32'h5);
    repeat (3)
    begin
      wait_flag(ST_CONV);
      acc(1'b1, OFS_STATUS, 32'h4);
    end
    wait_flag(ST_CONV);
    acc(1'b0, OFS_RESULT, 32'h0);
    chk(rd, 32'h0);
    acc(1'b1, OFS_CTRL, 32'h10);
    acc(1'b0, OFS_STATUS, 32'h0);
    acc(1'b0, OFS_STATUS, 32'h0);
    chk({31'h0, rd[ST_BUSY]}, 32'h0);
    acc(1'b1, OFS_STATUS, 32'he);
  endtask : t_continuous_select

  task t_mic;
    acc(1'b1, OFS_CORR, 32'h0);
    acc(1'b1, OFS_CONF, 32'h0c30);
    pdm_period(32'd78);
    acc(1'b1, OFS_CONF, 32'h0400);
    repeat (200) @(posedge i_mclk);
    acc(1'b1, OFS_CONF, 32'h1c30);
    pdm_period(32'd156);
    acc(1'b1, OFS_STATUS, 32'he);
    acc(1'b1, OFS_CTRL, 32'h20);
    wait_flag(ST_CONV);
    acc(1'b0, OFS_RESULT, 32'h0);
    chk(rd, 32'h20);
    acc(1'b1, OFS_CTRL, 32'h10);
    acc(1'b1, OFS_CONF, 32'h0);
    acc(1'b0, OFS_CONF, 32'h0);
    chk({31'h0, o_pdm_clock_out}, 32'h0);
  endtask : t_mic

  task print_verdict;
    $display("errors %0d comparisons %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : print_verdict

  //////////////////////////////////////////////////////////////////////////
  initial
  begin
    i_mclk = 1'b0;
    forever #4 i_mclk = ~i_mclk;
  end

  initial
  begin
    #800_000;
    n_errors++;
    print_verdict;
  end

  initial
  begin
    i_sys_rst   = 1'b1;
    i_address   = 6'h00;
    i_read      = 1'b0;
    i_write     = 1'b0;
    i_writedata = 32'h0;
    i_mod_bit   = 1'b0;
    repeat (10) @(posedge i_mclk);
    i_sys_rst <= 1'b0;
    @(posedge i_mclk);
    t_regs;
    t_single;
    t_calib;
    t_keep;
    t_upper;
    t_continuous_select;
    t_mic;
    print_verdict;
  end
endmodule : adc_conversion_control_tb_top
